// *** rtl/atc_map.vh ***
// Register map, fields, codes and timing counts of the track/start control.
`ifndef ATC_MAP_VH
`define ATC_MAP_VH

// Register indices, decoded from bus address bits [3:2].
`define ATC_IDX_CTRL 2'h0
`define ATC_IDX_IRQ_STAT 2'h1
`define ATC_IDX_IRQ_MASK 2'h2
`define ATC_IDX_LO 2
`define ATC_IDX_HI 3

// Control register fields and reset value.
`define ATC_CTRL_RESET 8'h00
`define ATC_BIT_ENABLE 7
`define ATC_BIT_TRACK_MODE 6
`define ATC_BIT_DONE 5
`define ATC_BIT_BUSY 4
`define ATC_BIT_WINDOW 3
`define ATC_TRIG_HI 2
`define ATC_TRIG_LO 0

// Start trigger select codes.
`define ATC_TRIG_SW 3'h0
`define ATC_TRIG_TMR0 3'h1
`define ATC_TRIG_TMR1 3'h2
`define ATC_TRIG_TMR2 3'h3
`define ATC_TRIG_EXT 3'h4
`define ATC_TRIG_TMR3 3'h5

// Interrupt status and mask layout.
`define ATC_IRQ_DONE 0
`define ATC_IRQ_WINDOW 1
`define ATC_IRQ_RESET 2'h0

// Low-power tracking window in SAR clocks.
`define ATC_LP_TRACK_SAR 5'h03

`endif

// *** rtl/atc_sar_div.v ***
// SAR clock divider producing a one-cycle tick every DIV system clocks.
`timescale 1ns/100ps
module atc_sar_div #(
  parameter DIV = 2
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_restart,
  output reg o_tick
);
  reg [7:0] count;

  // Restart aligns the first SAR period with the start of a phase, so
  // every tracking and conversion phase lasts whole SAR clocks.
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      count <= 8'h00;
      o_tick <= 1'b0;
    end
    else if (i_restart)
    begin
      // The restart edge is the first system clock of the new period, so
      // the registered tick is seen exactly DIV edges after it.
      count <= (DIV == 1) ? 8'h00 : 8'h01;
      o_tick <= (DIV == 1);
    end
    else if (count == DIV[7:0] - 8'h01)
    begin
      count <= 8'h00;
      o_tick <= 1'b1;
    end
    else
    begin
      count <= count + 8'h01;
      o_tick <= 1'b0;
    end
  end
endmodule

// *** rtl/atc_sync.v ***
// Three-stage synchroniser with agreement filter for one pin input.
`timescale 1ns/100ps
module atc_sync (
  input wire i_clk,
  input wire i_reset,
  input wire i_async,
  output reg o_level
);
  reg meta;
  reg s2;
  reg s3;

  // The first stage feeds only the second; the level moves when two and
  // three agree, so a single sampled glitch is never taken as an edge.
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      meta <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      meta <= i_async;
      s2 <= meta;
      s3 <= s2;
      if (s2 == s3)
        o_level <= s3;
    end
  end
endmodule

// *** rtl/atc_top.v ***
// Track-and-hold and start-of-conversion control with a Wishbone slave.
`timescale 1ns/100ps
`include "atc_map.vh"

// What this block does
// - Track mode clear: input tracked whenever enabled and idle.
// - Track mode set: three SAR clocks of tracking follow a trigger, except with strobe code 100.
// - Low-power strobe mode tracks while low, converts on the rise.
// - Enable clear shuts the converter down; set makes it ready.
// - Busy reads one while a conversion or its low-power tracking window runs and zero otherwise.
// - Normal mode code 100 starts on each strobe rising edge.
// - Normal mode code 101 starts on each timer 3 overflow.
// - Standby or sleep forces shutdown and stops tracking.
module atc_top #(
  parameter SAR_DIV = 2,
  parameter CONV_SAR_CLKS = 11
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [3:0] i_wb_adr,
  input wire [31:0] i_wb_dat,
  input wire [3:0] i_wb_sel,
  output reg o_wb_ack,
  output reg [31:0] o_wb_dat,
  input wire i_ext_convert_strobe,
  input wire i_timer0_ovf,
  input wire i_timer1_ovf,
  input wire i_timer2_ovf,
  input wire i_timer3_ovf,
  input wire i_window_hit,
  input wire i_standby,
  output reg o_core_track,
  output reg o_core_convert,
  output reg o_core_shutdown,
  output reg o_conv_start,
  output reg o_conv_done,
  output reg o_irq
);
  localparam ST_OFF = 2'h0;
  localparam ST_IDLE = 2'h1;
  localparam ST_TRACK = 2'h2;
  localparam ST_CONV = 2'h3;
  localparam [4:0] CONV_LAST = CONV_SAR_CLKS[4:0] - 5'h01;
  localparam [4:0] TRACK_LAST = `ATC_LP_TRACK_SAR - 5'h01;

  reg conv_enable;
  reg track_mode_select;
  reg conv_done_flag;
  reg window_compare_flag;
  reg [2:0] start_trigger_select;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [4:0] sar_cnt;
  reg [4:0] next_sar_cnt;
  reg strobe_prev;
  reg trig;
  reg sar_restart;
  reg done_evt;
  reg next_track;
  reg [7:0] ctrl_read;

  wire strobe_lvl;
  wire strobe_rise;
  wire sar_tick;
  wire req;
  wire wr_fire;
  wire [1:0] reg_idx;
  wire ctrl_wr;
  wire stat_wr;
  wire mask_wr;
  wire sw_start;
  wire active;
  wire conv_in_progress;
  wire lp_window;
  wire [1:0] next_irq_status;

  atc_sync u_strobe_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async(i_ext_convert_strobe),
    .o_level(strobe_lvl)
  );

  atc_sar_div #(
    .DIV(SAR_DIV)
  ) u_sar_div (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_restart(sar_restart),
    .o_tick(sar_tick)
  );

  assign strobe_rise = strobe_lvl & ~strobe_prev;
  assign req = i_wb_cyc & i_wb_stb;
  // Writes land at the edge where the master samples ack high.
  assign wr_fire = req & i_wb_we & o_wb_ack & i_wb_sel[0];
  assign reg_idx = i_wb_adr[`ATC_IDX_HI:`ATC_IDX_LO];
  assign ctrl_wr = wr_fire && (reg_idx == `ATC_IDX_CTRL);
  assign stat_wr = wr_fire && (reg_idx == `ATC_IDX_IRQ_STAT);
  assign mask_wr = wr_fire && (reg_idx == `ATC_IDX_IRQ_MASK);
  // The code written in the same access decides whether busy starts.
  assign sw_start = ctrl_wr && i_wb_dat[`ATC_BIT_BUSY] &&
    (i_wb_dat[`ATC_TRIG_HI:`ATC_TRIG_LO] == `ATC_TRIG_SW);
  // Standby overrides the enable bit without changing what software reads.
  assign active = conv_enable & ~i_standby;
  // Busy covers the low-power tracking window too, since the trigger has
  // already been taken and a second one would be lost anyway.
  assign conv_in_progress = (state == ST_TRACK) ||
    (state == ST_CONV);
  // A software start takes the track mode of the byte that starts it, so
  // one write can both select low-power tracking and trigger.
  assign lp_window = sw_start ? i_wb_dat[`ATC_BIT_TRACK_MODE] :
    (track_mode_select && (start_trigger_select != `ATC_TRIG_EXT));

  always @*
  begin
    case (start_trigger_select)
      `ATC_TRIG_SW: trig = sw_start;
      `ATC_TRIG_TMR0: trig = i_timer0_ovf;
      `ATC_TRIG_TMR1: trig = i_timer1_ovf;
      `ATC_TRIG_TMR2: trig = i_timer2_ovf;
      `ATC_TRIG_EXT: trig = strobe_rise;
      `ATC_TRIG_TMR3: trig = i_timer3_ovf;
      default: trig = 1'b0;
    endcase
    // The code in the written byte decides a software start, whatever
    // code the register held before the write.
    if (sw_start)
      trig = 1'b1;
  end

  always @*
  begin
    next_state = state;
    next_sar_cnt = sar_cnt;
    sar_restart = 1'b0;
    done_evt = 1'b0;
    case (state)
      ST_OFF:
      begin
        if (active)
          next_state = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (!active)
          next_state = ST_OFF;
        else if (trig)
        begin
          sar_restart = 1'b1;
          next_sar_cnt = 5'h00;
          // The strobe low time already served as the tracking window.
          if (lp_window)
            next_state = ST_TRACK;
          else
            next_state = ST_CONV;
        end
      end
      ST_TRACK:
      begin
        if (!active)
          next_state = ST_OFF;
        else if (sar_tick)
        begin
          if (sar_cnt == TRACK_LAST)
          begin
            next_state = ST_CONV;
            next_sar_cnt = 5'h00;
          end
          else
            next_sar_cnt = sar_cnt + 5'h01;
        end
      end
      ST_CONV:
      begin
        // Dropping enable mid-conversion aborts without a done event.
        if (!active)
          next_state = ST_OFF;
        else if (sar_tick)
        begin
          if (sar_cnt == CONV_LAST)
          begin
            next_state = ST_IDLE;
            done_evt = 1'b1;
          end
          else
            next_sar_cnt = sar_cnt + 5'h01;
        end
      end
      default: next_state = ST_OFF;
    endcase
  end

  // Tracking follows the state that the next edge enters.
  always @*
  begin
    case (next_state)
      ST_IDLE:
      begin
        if (!track_mode_select)
          next_track = 1'b1;
        else
          next_track = (start_trigger_select == `ATC_TRIG_EXT) &&
            !strobe_lvl;
      end
      ST_TRACK: next_track = 1'b1;
      default: next_track = 1'b0;
    endcase
  end

  // Hardware set wins over a software clear in the same cycle.
  assign next_irq_status = (irq_status &
    ~(stat_wr ? i_wb_dat[1:0] : 2'h0)) |
    {i_window_hit, done_evt};

  always @*
  begin
    ctrl_read = `ATC_CTRL_RESET;
    ctrl_read[`ATC_BIT_ENABLE] = conv_enable;
    ctrl_read[`ATC_BIT_TRACK_MODE] = track_mode_select;
    ctrl_read[`ATC_BIT_DONE] = conv_done_flag;
    ctrl_read[`ATC_BIT_BUSY] = conv_in_progress;
    ctrl_read[`ATC_BIT_WINDOW] = window_compare_flag;
    ctrl_read[`ATC_TRIG_HI:`ATC_TRIG_LO] = start_trigger_select;
  end

  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      conv_enable <= 1'b0;
      track_mode_select <= 1'b0;
      conv_done_flag <= 1'b0;
      window_compare_flag <= 1'b0;
      start_trigger_select <= `ATC_TRIG_SW;
      irq_status <= `ATC_IRQ_RESET;
      irq_mask <= `ATC_IRQ_RESET;
      state <= ST_OFF;
      sar_cnt <= 5'h00;
      strobe_prev <= 1'b0;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
      o_core_track <= 1'b0;
      o_core_convert <= 1'b0;
      o_core_shutdown <= 1'b1;
      o_conv_start <= 1'b0;
      o_conv_done <= 1'b0;
      o_irq <= 1'b0;
    end
    else
    begin
      strobe_prev <= strobe_lvl;
      state <= next_state;
      sar_cnt <= next_sar_cnt;
      if (ctrl_wr)
      begin
        conv_enable <= i_wb_dat[`ATC_BIT_ENABLE];
        track_mode_select <= i_wb_dat[`ATC_BIT_TRACK_MODE];
        start_trigger_select <= i_wb_dat[`ATC_TRIG_HI:`ATC_TRIG_LO];
      end
      // Writing zero clears a flag, writing one leaves it; an event wins.
      if (done_evt)
        conv_done_flag <= 1'b1;
      else if (ctrl_wr && !i_wb_dat[`ATC_BIT_DONE])
        conv_done_flag <= 1'b0;
      if (i_window_hit)
        window_compare_flag <= 1'b1;
      else if (ctrl_wr && !i_wb_dat[`ATC_BIT_WINDOW])
        window_compare_flag <= 1'b0;
      irq_status <= next_irq_status;
      if (mask_wr)
        irq_mask <= i_wb_dat[1:0];
      o_irq <= |(next_irq_status & (mask_wr ? i_wb_dat[1:0] : irq_mask));
      o_wb_ack <= req & ~o_wb_ack;
      if (req && !o_wb_ack)
      begin
        case (reg_idx)
          `ATC_IDX_CTRL: o_wb_dat <= {24'h000000, ctrl_read};
          `ATC_IDX_IRQ_STAT: o_wb_dat <= {30'h00000000, irq_status};
          `ATC_IDX_IRQ_MASK: o_wb_dat <= {30'h00000000, irq_mask};
          default: o_wb_dat <= 32'h00000000;
        endcase
      end
      o_core_shutdown <= (next_state == ST_OFF);
      o_core_track <= next_track;
      o_core_convert <= (next_state == ST_CONV);
      // Start marks the edge at which a trigger is taken, in either mode.
      o_conv_start <= (state == ST_IDLE) && (next_state != ST_IDLE) &&
        (next_state != ST_OFF);
      o_conv_done <= done_evt;
    end
  end
endmodule

// *** testbench/atc_partner.sv ***
// Timer overflow sources and convert-strobe pin beside the control block.
`timescale 1ns/100ps
module atc_partner (
  input wire i_clk,
  input wire [3:0] i_fire,
  input wire i_pin,
  output reg [3:0] o_ovf = 4'h0,
  output reg o_strobe = 1'b0
);
  // Overflows are single-cycle pulses on the system clock, as timers give.
  always @(posedge i_clk)
  begin
    o_ovf <= i_fire;
    o_strobe <= i_pin;
  end
endmodule

// *** testbench/atc_top_monitor.sv ***
// Port-level assertions for the track and start control block.
`timescale 1ns/100ps
module atc_top_monitor #(
  parameter SAR_DIV = 2,
  parameter CONV_SAR_CLKS = 11
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_standby,
  input wire o_wb_ack,
  input wire o_core_track,
  input wire o_core_convert,
  input wire o_core_shutdown,
  input wire o_conv_start,
  input wire o_conv_done
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic [7:0] conv_len;
  // Length of the running convert phase, read when the done pulse shows.
  always @(posedge i_clk)
  begin
    if (i_reset || !o_core_convert)
      conv_len <= 8'h00;
    else
      conv_len <= conv_len + 8'h01;
  end
  AST_ACK_LAT: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus request not acknowledged next cycle");
  AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  AST_STANDBY: assert property (
    i_standby |-> ##[1:2] o_core_shutdown)
    else $error("standby did not shut the converter down");
  AST_SHUT_IDLE: assert property (o_core_shutdown |->
    !o_core_track && !o_core_convert && !o_conv_start)
    else $error("shutdown converter is active");
  AST_EXCL: assert property (!(o_core_track && o_core_convert))
    else $error("track and convert high together");
  AST_CONV_LEN: assert property (o_conv_done |->
    conv_len == CONV_SAR_CLKS * SAR_DIV)
    else $error("conversion length wrong");
  AST_START: assert property (o_conv_start |->
    (o_core_convert || o_core_track) ##1 !o_conv_start)
    else $error("start pulse without track or convert");
  AST_DONE: assert property (
    o_conv_done |-> !o_core_convert ##1 !o_conv_done)
    else $error("done pulse malformed");
endmodule
bind atc_top atc_top_monitor #(.SAR_DIV(SAR_DIV),
  .CONV_SAR_CLKS(CONV_SAR_CLKS))
  u_atc_top_monitor (.i_clk, .i_reset, .i_wb_cyc, .i_wb_stb, .i_standby,
  .o_wb_ack, .o_core_track, .o_core_convert, .o_core_shutdown, .o_conv_start,
  .o_conv_done);

// *** testbench/atc_top_test.sv ***
// Register-level test sequence for the track and start control block.
`timescale 1ns/100ps
`include "atc_map.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module atc_top_test;
  logic i_clk = 1'b0, i_reset = 1'b1, cyc = 1'b0, we = 1'b0;
  logic pin = 1'b0, win = 1'b0, stby = 1'b0;
  logic [3:0] adr = 4'h0, fire = 4'h0;
  logic [31:0] wdat = 32'h0, rd;
  logic [7:0] trk_run = 8'h00, trk_len = 8'h00;
  logic cnv_q = 1'b0;
  wire ack, trk, cnv, shd, st, dn, irq, strobe;
  wire [31:0] rdat;
  wire [3:0] ovf;
  int n_mismatch = 0, comparisons = 0, k;
  atc_top u_atc_top (.i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(cyc),
    .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
    .i_wb_sel(4'hF), .o_wb_ack(ack), .o_wb_dat(rdat),
    .i_ext_convert_strobe(strobe), .i_timer0_ovf(ovf[0]),
    .i_timer1_ovf(ovf[1]), .i_timer2_ovf(ovf[2]), .i_timer3_ovf(ovf[3]),
    .i_window_hit(win), .i_standby(stby), .o_core_track(trk),
    .o_core_convert(cnv), .o_core_shutdown(shd), .o_conv_start(st),
    .o_conv_done(dn), .o_irq(irq));
  atc_partner u_atc_partner (.i_clk(i_clk), .i_fire(fire), .i_pin(pin),
    .o_ovf(ovf), .o_strobe(strobe));
  initial forever #20 i_clk = ~i_clk;
  // Tracking cycles seen just before each convert phase begins.
  always @(posedge i_clk)
  begin
    cnv_q <= cnv;
    trk_run <= (trk && !cnv) ? trk_run + 8'h01 : 8'h00;
    if (cnv && !cnv_q)
      trk_len <= trk_run;
  end
  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int t;
    t = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    @(posedge i_clk);
    while (ack !== 1'b1 && t < 50)
    begin
      t++;
      @(posedge i_clk);
    end
    rd = rdat;
    cyc <= 1'b0;
    if (t == 50)
    begin
      n_mismatch++;
      print_verdict;
    end
    @(posedge i_clk);
  endtask
  task automatic wait_done;
    int t;
    t = 0;
    while (dn !== 1'b1 && t < 300)
    begin
      t++;
      @(posedge i_clk);
    end
    if (t == 300)
    begin
      n_mismatch++;
      print_verdict;
    end
  endtask
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    `CHK(shd, 1'b1)
    for (k = 0; k < 4; k++)
    begin
      wb(1'b0, 4'(k * 4), 8'h00);
      `CHK(rd, 32'h00000000)
    end
    wb(1'b1, 4'h8, 8'h03);
    wb(1'b1, 4'h0, 8'h80);
    repeat (2) @(posedge i_clk);
    `CHK({shd, trk, cnv}, 3'b010)
    wb(1'b1, 4'h0, 8'h80);
    repeat (3) @(posedge i_clk);
    `CHK({st, cnv}, 2'b00)
    wb(1'b1, 4'h0, 8'h90);
    wb(1'b0, 4'h0, 8'h00);
    `CHK(rd[4], 1'b1)
    wait_done;
    repeat (2) @(posedge i_clk);
    wb(1'b0, 4'h0, 8'h00);
    `CHK(rd[7:0], 8'hA0)
    `CHK(irq, 1'b1)
    wb(1'b1, 4'h0, 8'h80);
    wb(1'b1, 4'h4, 8'h01);
    wb(1'b0, 4'h0, 8'h00);
    `CHK({rd[7:0], irq}, 9'h100)
    for (k = 1; k < 6; k++)
    begin
      wb(1'b1, 4'h0, 8'h80 | 8'(k));
      repeat (8) @(posedge i_clk);
      if (k == 4)
        pin <= 1'b1;
      else
        fire <= 4'h1 << ((k == 5) ? 3 : k - 1);
      @(posedge i_clk);
      fire <= 4'h0;
      wait_done;
      pin <= 1'b0;
      wb(1'b0, 4'h4, 8'h00);
      `CHK(rd[0], 1'b1)
      wb(1'b1, 4'h4, 8'h01);
    end
    wb(1'b1, 4'h0, 8'h86);
    fire <= 4'hF;
    @(posedge i_clk);
    fire <= 4'h0;
    repeat (4) @(posedge i_clk);
    `CHK({st, cnv}, 2'b00)
    // Low-power idle does not track, so the run counter starts from zero.
    wb(1'b1, 4'h0, 8'hC0);
    wb(1'b1, 4'h0, 8'hD0);
    wait_done;
    `CHK(trk_len, 8'h06)
    wb(1'b1, 4'h0, 8'hD4);
    repeat (6) @(posedge i_clk);
    `CHK({trk, cnv}, 2'b10)
    pin <= 1'b1;
    wait_done;
    `CHK({dn, trk}, 2'b10)
    pin <= 1'b0;
    repeat (8) @(posedge i_clk);
    `CHK({trk, cnv}, 2'b10)
    win <= 1'b1;
    @(posedge i_clk);
    win <= 1'b0;
    wb(1'b0, 4'h0, 8'h00);
    `CHK({rd[3], irq}, 2'b11)
    wb(1'b1, 4'h0, 8'h80);
    stby <= 1'b1;
    repeat (3) @(posedge i_clk);
    `CHK({shd, trk}, 2'b10)
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    `CHK({shd, trk, cnv, irq}, 4'b1000)
    wb(1'b0, 4'h0, 8'h00);
    `CHK(rd, 32'h00000000)
    print_verdict;
  end
endmodule
